/* File: hdl/fixing_pkg.sv */
// constants and carriers for the fixing heater thermal supervisor
package fixing_pkg;
	localparam int TEMP_W = 10;
	localparam int CODE_W = 8;
	// temperatures in whole degrees celsius
	localparam logic [TEMP_W-1:0] TEMP_STANDBY = 10'h0a5;
	localparam logic [TEMP_W-1:0] TEMP_PRINT = 10'h0b4;
	localparam logic [TEMP_W-1:0] TEMP_COLD = 10'h01e;
	localparam logic [TEMP_W-1:0] TEMP_OVER = 10'h0e6;
	localparam logic [TEMP_W-1:0] TEMP_UNDER = 10'h08c;
	// service code 50, decimal digits packed as bcd
	localparam logic [CODE_W-1:0] CODE_FIXING = 8'h50;
	localparam logic [CODE_W-1:0] CODE_NONE = 8'h00;
	// warm-up limits
	localparam longint CLK_HZ = 40000000;
	localparam longint COLD_LIMIT_S = 18;
	localparam longint WARM_LIMIT_S = 90;
	localparam longint COLD_LIMIT_CYC = COLD_LIMIT_S * CLK_HZ;
	localparam longint WARM_LIMIT_CYC = WARM_LIMIT_S * CLK_HZ;
	localparam int TIMER_W = 32;

	typedef enum logic [1:0] {
		PH_WARMUP = 2'b00,
		PH_READY = 2'b01,
		PH_FAULT = 2'b10
	} phase_t;

	typedef struct packed {
		logic heater_on;
		logic heater_fault;
		logic ready_permit;
		logic warm_done;
		logic jam_lamp;
		logic beeper;
		logic [CODE_W-1:0] service_code;
	} fixing_status_t;
endpackage

/* File: hdl/warmup_timer.sv */
// power-on elapsed timer flagging the two warm-up deadlines
module warmup_timer #(
	parameter logic [fixing_pkg::TIMER_W-1:0] COLD_CYC = fixing_pkg::TIMER_W'(fixing_pkg::COLD_LIMIT_CYC),
	parameter logic [fixing_pkg::TIMER_W-1:0] WARM_CYC = fixing_pkg::TIMER_W'(fixing_pkg::WARM_LIMIT_CYC)
) (
	input wire logic mclk,
	input wire logic rst,
	output logic cold_expired,
	output logic warm_expired
);
	logic [fixing_pkg::TIMER_W-1:0] elapsed;

	// saturates once the later deadline passes, so no wraparound false alarm
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			elapsed <= '0;
		end else if (!warm_expired) begin
			elapsed <= elapsed + 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cold_expired <= 1'b0;
			warm_expired <= 1'b0;
		end else begin
			if (elapsed >= COLD_CYC - 1'b1) begin
				cold_expired <= 1'b1;
			end
			if (elapsed >= WARM_CYC - 1'b1) begin
				warm_expired <= 1'b1;
			end
		end
	end
endmodule

/* File: hdl/fixing_heater_thermal_supervisor.sv */
// fixing roller temperature regulator and thermal fault supervisor
module fixing_heater_thermal_supervisor #(
	parameter logic [fixing_pkg::TIMER_W-1:0] COLD_CYC = fixing_pkg::TIMER_W'(fixing_pkg::COLD_LIMIT_CYC),
	parameter logic [fixing_pkg::TIMER_W-1:0] WARM_CYC = fixing_pkg::TIMER_W'(fixing_pkg::WARM_LIMIT_CYC)
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [fixing_pkg::TEMP_W-1:0] roller_temp_sensor,
	input wire logic print_active,
	input wire logic cover_test_switch,
	input wire logic paper_jam,
	output logic heater_on,
	output logic heater_fault_out,
	output logic ready_permit,
	output logic warm_done,
	output logic jam_lamp,
	output logic beeper,
	output logic [fixing_pkg::CODE_W-1:0] service_code
);
	fixing_pkg::phase_t phase;
	fixing_pkg::phase_t next_phase;
	fixing_pkg::fixing_status_t next_status;
	logic cold_expired;
	logic warm_expired;
	logic reached_30;
	logic reached_165;
	logic fault_now;
	logic jam_latched;
	logic [fixing_pkg::TEMP_W-1:0] setpoint;

	// ------------------------------------------------------------
	// deadlines
	// ------------------------------------------------------------
	warmup_timer #(
		.COLD_CYC(COLD_CYC),
		.WARM_CYC(WARM_CYC)
	) u_timer (
		.mclk(mclk),
		.rst(rst),
		.cold_expired(cold_expired),
		.warm_expired(warm_expired)
	);

	// ------------------------------------------------------------
	// warm-up progress
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reached_30 <= 1'b0;
			reached_165 <= 1'b0;
		end else begin
			if (roller_temp_sensor > fixing_pkg::TEMP_COLD) begin
				reached_30 <= 1'b1;
			end
			if (roller_temp_sensor > fixing_pkg::TEMP_STANDBY) begin
				reached_165 <= 1'b1;
			end
		end
	end

	// jam stays until reset; the engine restarts from power-on
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			jam_latched <= 1'b0;
		end else if (paper_jam) begin
			jam_latched <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// fault detection
	// ------------------------------------------------------------
	always_comb begin
		fault_now = 1'b0;
		if (cold_expired && !reached_30) begin
			fault_now = 1'b1;
		end
		if (warm_expired && !reached_165) begin
			fault_now = 1'b1;
		end
		if (roller_temp_sensor > fixing_pkg::TEMP_OVER) begin
			fault_now = 1'b1;
		end
		if (phase == fixing_pkg::PH_READY && roller_temp_sensor < fixing_pkg::TEMP_UNDER) begin
			fault_now = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// phase
	// ------------------------------------------------------------
	always_comb begin
		next_phase = phase;
		unique case (phase)
			fixing_pkg::PH_WARMUP: begin
				if (fault_now) begin
					next_phase = fixing_pkg::PH_FAULT;
				end else if (roller_temp_sensor >= fixing_pkg::TEMP_STANDBY) begin
					next_phase = fixing_pkg::PH_READY;
				end
			end
			fixing_pkg::PH_READY: begin
				if (fault_now) begin
					next_phase = fixing_pkg::PH_FAULT;
				end
			end
			fixing_pkg::PH_FAULT: next_phase = fixing_pkg::PH_FAULT;
			default: next_phase = fixing_pkg::PH_FAULT;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phase <= fixing_pkg::PH_WARMUP;
		end else begin
			phase <= next_phase;
		end
	end

	// ------------------------------------------------------------
	// regulation and outputs
	// ------------------------------------------------------------
	// print request overrides standby with no ramp
	assign setpoint = print_active ? fixing_pkg::TEMP_PRINT : fixing_pkg::TEMP_STANDBY;

	always_comb begin
		next_status = '0;
		next_status.service_code = fixing_pkg::CODE_NONE;
		// bang-bang; at exactly the setpoint the drive is left as it was
		if (roller_temp_sensor < setpoint) begin
			next_status.heater_on = 1'b1;
		end else if (roller_temp_sensor > setpoint) begin
			next_status.heater_on = 1'b0;
		end else begin
			next_status.heater_on = heater_on;
		end
		if (cover_test_switch) begin
			next_status.heater_on = 1'b0;
		end
		if (jam_latched || paper_jam) begin
			next_status.heater_on = 1'b0;
			next_status.jam_lamp = 1'b1;
			next_status.beeper = 1'b1;
		end
		next_status.warm_done = (next_phase == fixing_pkg::PH_READY);
		next_status.ready_permit = (next_phase == fixing_pkg::PH_READY) && !next_status.jam_lamp;
		if (next_phase == fixing_pkg::PH_FAULT) begin
			next_status.heater_on = 1'b0;
			next_status.heater_fault = 1'b1;
			next_status.service_code = fixing_pkg::CODE_FIXING;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			heater_on <= 1'b0;
			heater_fault_out <= 1'b0;
			ready_permit <= 1'b0;
			warm_done <= 1'b0;
			jam_lamp <= 1'b0;
			beeper <= 1'b0;
			service_code <= fixing_pkg::CODE_NONE;
		end else begin
			heater_on <= next_status.heater_on;
			heater_fault_out <= next_status.heater_fault;
			ready_permit <= next_status.ready_permit;
			warm_done <= next_status.warm_done;
			jam_lamp <= next_status.jam_lamp;
			beeper <= next_status.beeper;
			service_code <= next_status.service_code;
		end
	end
endmodule

/* File: bench/roller_model.sv */
// roller, heater relay and thermistor model
module roller_model (
	input wire logic mclk,
	input wire logic heater_on,
	input wire logic cover_test_switch,
	input wire logic forced,
	input wire logic [fixing_pkg::TEMP_W-1:0] forced_temp,
	output logic [fixing_pkg::TEMP_W-1:0] roller_temp_sensor
);
	logic [fixing_pkg::TEMP_W-1:0] temp = 10'h0014;
	// a degree a cycle, far quicker than a real roller to keep runs short
	always_ff @(posedge mclk) begin
		if (heater_on)
			temp <= temp + 10'h0001;
		else if (temp > 10'h0014)
			temp <= temp - 10'h0001;
	end
	// dummy load reads as a warmed roller
	assign roller_temp_sensor = cover_test_switch ? 10'h00aa : (forced ? forced_temp : temp);
endmodule

/* File: bench/fixing_properties.sv */
// port checker for the fixing heater thermal supervisor
module fixing_properties (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [fixing_pkg::TEMP_W-1:0] roller_temp_sensor,
	input wire logic print_active,
	input wire logic cover_test_switch,
	input wire logic paper_jam,
	input wire logic heater_on,
	input wire logic heater_fault_out,
	input wire logic ready_permit,
	input wire logic warm_done,
	input wire logic jam_lamp,
	input wire logic beeper,
	input wire logic [fixing_pkg::CODE_W-1:0] service_code
);
	logic [fixing_pkg::TEMP_W-1:0] sp;
	assign sp = print_active ? fixing_pkg::TEMP_PRINT : fixing_pkg::TEMP_STANDBY;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_heat_below: assert property (
		!cover_test_switch && !paper_jam && !jam_lamp && !heater_fault_out
		&& roller_temp_sensor >= fixing_pkg::TEMP_UNDER && roller_temp_sensor < sp
		|=> heater_on || heater_fault_out) else $error("heater off below setpoint");
	chk_heat_above: assert property (
		roller_temp_sensor > sp |=> !heater_on) else $error("heater on above setpoint");
	chk_over_fault: assert property (
		roller_temp_sensor > fixing_pkg::TEMP_OVER |=> heater_fault_out) else $error("no over fault");
	chk_under_fault: assert property (
		ready_permit && roller_temp_sensor < fixing_pkg::TEMP_UNDER |=> heater_fault_out)
		else $error("no under fault");
	chk_fault_code: assert property (
		heater_fault_out |-> service_code == fixing_pkg::CODE_FIXING && !heater_on && !ready_permit)
		else $error("fault outputs wrong");
	chk_code_idle: assert property (
		!heater_fault_out |-> service_code == fixing_pkg::CODE_NONE) else $error("stray code");
	chk_fault_hold: assert property (
		heater_fault_out |=> heater_fault_out) else $error("fault dropped");
	chk_cover_off: assert property (
		cover_test_switch |=> !heater_on) else $error("heater on with cover off");
	chk_jam_stop: assert property (
		paper_jam |=> jam_lamp && beeper && !heater_on) else $error("jam not handled");
	chk_ready_gate: assert property (
		$rose(ready_permit) |-> warm_done && $past(roller_temp_sensor) >= fixing_pkg::TEMP_STANDBY)
		else $error("ready too early");
	cover property ($rose(heater_fault_out));
	cover property ($rose(ready_permit));
	cover property ($rose(jam_lamp));
endmodule
bind fixing_heater_thermal_supervisor fixing_properties i_chk (.mclk(mclk), .rst(rst),
	.roller_temp_sensor(roller_temp_sensor), .print_active(print_active),
	.cover_test_switch(cover_test_switch), .paper_jam(paper_jam), .heater_on(heater_on),
	.heater_fault_out(heater_fault_out), .ready_permit(ready_permit), .warm_done(warm_done),
	.jam_lamp(jam_lamp), .beeper(beeper), .service_code(service_code));

/* File: bench/tb.sv */
// self-checking bench for the fixing heater thermal supervisor
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int COLD = 50;
	localparam int WARM = 200;
	logic mclk = 0, rst = 1, print_active = 0, cover_test_switch = 0, paper_jam = 0, forced = 0;
	logic [fixing_pkg::TEMP_W-1:0] forced_temp = 10'h0000, temp;
	logic heater_on, heater_fault_out, ready_permit, warm_done, jam_lamp, beeper;
	logic [fixing_pkg::CODE_W-1:0] service_code;
	int mismatches = 0, compares = 0;
	always #12.5 mclk = ~mclk;
	roller_model i_roller (.mclk(mclk), .heater_on(heater_on), .cover_test_switch(cover_test_switch),
		.forced(forced), .forced_temp(forced_temp), .roller_temp_sensor(temp));
	fixing_heater_thermal_supervisor #(.COLD_CYC(COLD), .WARM_CYC(WARM)) i_dut (.mclk(mclk),
		.rst(rst), .roller_temp_sensor(temp), .print_active(print_active),
		.cover_test_switch(cover_test_switch), .paper_jam(paper_jam), .heater_on(heater_on),
		.heater_fault_out(heater_fault_out), .ready_permit(ready_permit), .warm_done(warm_done),
		.jam_lamp(jam_lamp), .beeper(beeper), .service_code(service_code));
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic do_reset;
		rst = 1;
		tick(3);
		rst = 0;
	endtask
	task automatic t_warm;
		int n;
		forced = 0;
		do_reset();
		for (n = 0; n < 300 && warm_done !== 1'b1; n++)
			tick(1);
		check({9'h000, temp >= fixing_pkg::TEMP_STANDBY}, 1, "warm temp");
		check(ready_permit, 1, "ready");
		check(warm_done, 1, "warm done");
		// drive is held at the setpoint itself, drops one edge later
		tick(1);
		check(heater_on, 0, "standby off");
		print_active = 1;
		tick(2);
		check(heater_on, 1, "print heat");
		forced = 1;
		forced_temp = 10'h008b;
		tick(2);
		check(heater_fault_out, 1, "under fault");
		check(service_code, fixing_pkg::CODE_FIXING, "code");
		forced = 0;
		print_active = 0;
		tick(20);
		check({heater_fault_out, heater_on}, 2, "latched");
	endtask
	task automatic t_limit(input logic [9:0] t, input int lim);
		forced = 1;
		forced_temp = t;
		do_reset();
		tick(lim);
		check(heater_fault_out, 0, "early fault");
		check(heater_on, 1, "cold heat");
		tick(1);
		check(heater_fault_out, 1, "late fault");
		check(service_code, fixing_pkg::CODE_FIXING, "code");
	endtask
	task automatic t_jam_over;
		forced_temp = 10'h0064;
		do_reset();
		tick(3);
		paper_jam = 1;
		tick(1);
		paper_jam = 0;
		tick(1);
		check({jam_lamp, beeper, heater_on}, 6, "jam");
		forced_temp = 10'h00e7;
		tick(2);
		check(heater_fault_out, 1, "over fault");
	endtask
	task automatic t_cover;
		forced = 0;
		cover_test_switch = 1;
		do_reset();
		tick(30);
		check({heater_on, heater_fault_out}, 0, "cover");
		cover_test_switch = 0;
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		t_warm();
		t_limit(10'h0019, COLD);
		t_limit(10'h0064, WARM);
		t_jam_over();
		t_cover();
		complete_run();
	end
	// whole run is under a thousand cycles
	initial begin
		#(5000 * 25);
		mismatches++;
		complete_run();
	end
endmodule
